// ### case_sup_pkg.sv
// Shared constants, encodings and timing figures for the monitoring case supervisor.
// Assumes a single 200 MHz clock; every slower rate is derived from it.
package case_sup_pkg;

	// Clock and derived time bases
	localparam longint REF_CLK_HZ       = 200_000_000;
	localparam longint CLK_PER_MS       = REF_CLK_HZ / 1000;
	localparam longint CLK_PER_US       = REF_CLK_HZ / 1_000_000;

	// Least settle time of static control inputs
	localparam longint SETTLE_TIME_MS   = 12;
	localparam longint SETTLE_CYCLES    = SETTLE_TIME_MS * CLK_PER_MS;

	// Tolerated encoder mismatch in speed-limit mode
	localparam longint MISMATCH_HOLD_S  = 60;
	localparam longint MISMATCH_HOLD_MS = MISMATCH_HOLD_S * 1000;

	// Scan cycle length
	localparam longint SCAN_TIME_US     = 40;
	localparam longint SCAN_CYCLES      = SCAN_TIME_US * CLK_PER_US;

	// Structure sizes
	localparam int N_TABLES  = 2;
	localparam int TBL_W     = 1;
	localparam int N_CASES   = 8;
	localparam int CASE_W    = 3;
	localparam int N_INPUTS  = 4;
	localparam int N_PATHS   = 4;
	localparam int PATH_W    = 2;
	localparam int N_UNIV    = 4;
	localparam int SPEED_W   = 16;
	localparam int TOL_W     = 7;
	localparam int CNT_W     = 32;
	localparam int N_SUCC    = 2;

	// Percentage scale of the encoder tolerance
	localparam logic [CNT_W-1:0] PCT_FULL = 32'h0000_0064;

	// Behaviour of one cut-off path cell; zero is the unassigned default
	typedef enum logic [1:0] {
		BEH_OFF        = 2'b00,
		BEH_FIELD      = 2'b01,
		BEH_ON_NONSAFE = 2'b10,
		BEH_ON_SAFE    = 2'b11
	} cut_beh_t;

	// Speed usage of one monitoring case
	typedef enum logic [1:0] {
		SPD_NONE  = 2'b00,
		SPD_RANGE = 2'b01,
		SPD_LIMIT = 2'b10
	} spd_mode_t;

	// Supervisor states
	typedef enum logic [1:0] {
		ST_WAIT  = 2'b00,
		ST_RUN   = 2'b01,
		ST_ERROR = 2'b10
	} sup_state_t;

endpackage

// ### case_sel_if.sv
// Carrier between the supervisor and one monitoring case table selector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface case_sel_if
	import case_sup_pkg::*;
();
	// Evaluation inputs
	logic                                   eval;
	logic [N_INPUTS-1:0]                    comb;
	logic                                   use_speed;
	logic signed [SPEED_W-1:0]              speed;
	// Table configuration
	logic [N_INPUTS-1:0]                    inputs_used;
	logic [N_CASES-1:0][N_INPUTS-1:0]       case_comb;
	logic [N_CASES-1:0]                     case_use_inputs;
	logic [N_CASES-1:0][1:0]                spd_mode;
	logic [N_CASES-1:0][SPEED_W-1:0]        spd_min;
	logic [N_CASES-1:0][SPEED_W-1:0]        spd_max;
	logic [N_CASES-1:0][1:0]                succ_cnt;
	logic [N_CASES-1:0][N_SUCC-1:0][CASE_W-1:0] succ;
	logic [N_CASES-1:0]                     sleep_flag;
	// Results
	logic [CASE_W-1:0]                      active;
	logic                                   active_valid;
	logic                                   seq_fault;
	logic                                   cfg_fault;
	logic                                   sleep;
	logic                                   limit_viol;
	logic                                   limit_mode;

	modport supervisor (
		output eval, comb, use_speed, speed, inputs_used, case_comb, case_use_inputs,
		       spd_mode, spd_min, spd_max, succ_cnt, succ, sleep_flag,
		input  active, active_valid, seq_fault, cfg_fault, sleep, limit_viol, limit_mode
	);
	modport selector (
		input  eval, comb, use_speed, speed, inputs_used, case_comb, case_use_inputs,
		       spd_mode, spd_min, spd_max, succ_cnt, succ, sleep_flag,
		output active, active_valid, seq_fault, cfg_fault, sleep, limit_viol, limit_mode
	);
endinterface

// ### case_table_sel.sv
// Selector for one monitoring case table: matching, configuration check, switching order.
// Assumes settled inputs and a one-cycle evaluation pulse per scan cycle.
`timescale 1ns/1ps
module case_table_sel
	import case_sup_pkg::*;
(
	// Clock and reset
	input wire logic         ref_clk,
	input wire logic         srst,
	// Table link
	case_sel_if.selector     sel
);

	logic [N_CASES-1:0] uses_inputs;
	logic [N_CASES-1:0] case_bad;
	logic [N_CASES-1:0] match;
	logic               match_any;
	logic [CASE_W-1:0]  match_idx;
	logic [1:0]         eff_mode [N_CASES];
	logic               succ_ok;

	// Signed range test
	function automatic logic in_range(input logic [SPEED_W-1:0] v, lo, hi);
		in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
	endfunction

	// Per case: speed mode, configuration check and match
	for (genvar i = 0; i < N_CASES; i++)
	begin : g_case
		logic dup;
		assign eff_mode[i] = sel.use_speed ? sel.spd_mode[i] : SPD_NONE;
		assign uses_inputs[i] = (eff_mode[i] != SPD_RANGE) || sel.case_use_inputs[i];
		always_comb
		begin
			dup = 1'b0;
			for (int j = 0; j < i; j++)
				if (uses_inputs[j] && uses_inputs[i] && eff_mode[j] != SPD_RANGE &&
				    eff_mode[i] != SPD_RANGE && sel.case_comb[j] == sel.case_comb[i])
					dup = 1'b1;
		end
		// Invalid combinations and non-range repeats of a lower non-range case's combination never activate
		assign case_bad[i] = dup || (uses_inputs[i] && |(sel.case_comb[i] & ~sel.inputs_used));
		assign match[i] = !case_bad[i]
			&& (!uses_inputs[i] || ((sel.comb & sel.inputs_used) == sel.case_comb[i]))
			&& (eff_mode[i] != SPD_RANGE || in_range(sel.speed, sel.spd_min[i], sel.spd_max[i]));
	end

	// Lowest matching case wins
	always_comb
	begin
		match_any = 1'b0;
		match_idx = '0;
		for (int i = N_CASES - 1; i >= 0; i--)
			if (match[i])
			begin
				match_any = 1'b1;
				match_idx = CASE_W'(i);
			end
	end

	// Successor check: two slots hold the union of all sequences
	assign succ_ok = (sel.succ_cnt[sel.active] == 2'b00)
		|| (match_idx == sel.succ[sel.active][0])
		|| (sel.succ_cnt[sel.active] > 2'b01 && match_idx == sel.succ[sel.active][1]);

	// Active case update at the scan boundary
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			sel.active       <= '0;
			sel.active_valid <= 1'b0;
		end
		else if (sel.eval)
		begin
			if (!match_any)
				sel.active_valid <= 1'b0;
			else if (!sel.active_valid || succ_ok || match_idx == sel.active)
			begin
				sel.active       <= match_idx;
				sel.active_valid <= 1'b1;
			end
		end
	end

	// Switching order violation, held until reset
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			sel.seq_fault <= 1'b0;
		else if (sel.eval && match_any && sel.active_valid && match_idx != sel.active && !succ_ok)
			sel.seq_fault <= 1'b1;
	end

	// Table configuration fault and status of the active case
	assign sel.cfg_fault  = |case_bad;
	assign sel.sleep      = sel.active_valid && sel.sleep_flag[sel.active];
	assign sel.limit_mode = sel.active_valid && eff_mode[sel.active] == SPD_LIMIT;
	assign sel.limit_viol = sel.limit_mode
		&& !in_range(sel.speed, sel.spd_min[sel.active], sel.spd_max[sel.active]);

endmodule

// ### case_supervisor.sv
// Monitoring case supervisor: input conditioning, table selection, cut-off paths, outputs.
// Assumes static control pins are asynchronous; speeds and field states come from same-clock logic.
//
// Operation
// - Each case holds zero to two successors; none means any case may follow.
// - A case outside the permitted successors forces every safety output off.
// - All sequences together give at most two successors per case.
// - Each cut-off path is owned by exactly one monitoring case table.
// - After start, outputs stay off with waiting status until every table has a case.
// - A table losing its active case in operation turns outputs off and flags error.
// - A case flagged for sleep requests sleep while it is selected and the supervisor is running.
// - A case using inputs activates only on its exact combination; invalid ones and duplicate non-range ones fault.
// - Speed takes part in selection only when use-speed is enabled.
// - Range mode activates a case when speed lies inside its range.
// - Limit mode selects by inputs; speed out of range turns safety outputs off.
// - Limit mode tolerates encoder speed mismatch for up to 60 seconds.
// - One cut-off path per field drives its safety pair and universal outputs.
// - Always-off cell drives its cut-off path off.
// - Always-on non-safe holds safety outputs off and non-safety outputs on.
// - Always-on safe acts as a permanently clear field, path on.
// - Unassigned cells behave as always-off.
// - Antivalent channels not inverted force safety outputs off and flag error.
// - Inputs are evaluated only after the 12 ms or longer configured settle delay.
`timescale 1ns/1ps
module case_supervisor
	import case_sup_pkg::*;
#(
	parameter longint SETTLE_CNT   = SETTLE_CYCLES,
	parameter longint SCAN_CNT     = SCAN_CYCLES,
	parameter longint MS_CNT       = CLK_PER_MS,
	parameter longint MISMATCH_CNT = MISMATCH_HOLD_MS
)
(
	// Clock and reset
	input  wire logic                                           ref_clk,
	input  wire logic                                           srst,
	// Static control input pins, two channels each
	input  wire logic [N_INPUTS-1:0]                            ctl_a,
	input  wire logic [N_INPUTS-1:0]                            ctl_b,
	input  wire logic                                           antivalent_en,
	input  wire logic [CNT_W-1:0]                               input_delay_cfg,
	// Encoder speeds and tolerance
	input  wire logic signed [SPEED_W-1:0]                      enc_speed_a,
	input  wire logic signed [SPEED_W-1:0]                      enc_speed_b,
	input  wire logic [TOL_W-1:0]                               speed_tol_pct,
	// Per table configuration
	input  wire logic [N_TABLES-1:0]                            use_speed,
	input  wire logic [N_TABLES-1:0][N_INPUTS-1:0]              inputs_used,
	input  wire logic [N_TABLES-1:0][N_CASES-1:0][N_INPUTS-1:0] case_comb,
	input  wire logic [N_TABLES-1:0][N_CASES-1:0]               case_use_inputs,
	input  wire logic [N_TABLES-1:0][N_CASES-1:0][1:0]          spd_mode,
	input  wire logic [N_TABLES-1:0][N_CASES-1:0][SPEED_W-1:0]  spd_min,
	input  wire logic [N_TABLES-1:0][N_CASES-1:0][SPEED_W-1:0]  spd_max,
	input  wire logic [N_TABLES-1:0][N_CASES-1:0][1:0]          succ_cnt,
	input  wire logic [N_TABLES-1:0][N_CASES-1:0][N_SUCC-1:0][CASE_W-1:0] succ,
	input  wire logic [N_TABLES-1:0][N_CASES-1:0]               sleep_flag,
	input  wire logic [N_TABLES-1:0][N_CASES-1:0][N_PATHS-1:0][1:0] cell_beh,
	// Cut-off path configuration and field states
	input  wire logic [N_PATHS-1:0][TBL_W-1:0]                  path_table,
	input  wire logic [N_PATHS-1:0]                             path_pair_en,
	input  wire logic [N_UNIV-1:0][PATH_W-1:0]                  univ_path,
	input  wire logic [N_UNIV-1:0]                              univ_en,
	input  wire logic [N_PATHS-1:0]                             field_clear,
	// Outputs
	output logic [N_PATHS-1:0][1:0]                             safety_output_pair,
	output logic [N_UNIV-1:0]                                   universal_out,
	output logic [N_PATHS-1:0]                                  path_on,
	// Status
	output logic [N_TABLES-1:0][CASE_W-1:0]                     active_case,
	output logic [N_TABLES-1:0]                                 active_valid,
	output logic                                                waiting_for_inputs,
	output logic                                                error_out,
	output logic                                                seq_fault,
	output logic                                                cfg_fault,
	output logic                                                antivalent_fault,
	output logic                                                speed_fault,
	output logic                                                sleep_req
);

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers and antivalence check

	logic [N_INPUTS-1:0] a_meta;
	logic [N_INPUTS-1:0] a_sync;
	logic [N_INPUTS-1:0] b_meta;
	logic [N_INPUTS-1:0] b_sync;

	// Two flip-flops per pin; channel b idles inverted so a reset raises no false channel fault
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			a_meta <= '0;
			a_sync <= '0;
			b_meta <= '1;
			b_sync <= '1;
		end
		else
		begin
			a_meta <= ctl_a;
			a_sync <= a_meta;
			b_meta <= ctl_b;
			b_sync <= b_meta;
		end
	end

	// Channels must be inverted at all times
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			antivalent_fault <= 1'b0;
		else
			antivalent_fault <= antivalent_en && |(~(a_sync ^ b_sync));
	end

	////////////////////////////////////////////////////////////////////////////
	// Settle delay

	logic [CNT_W-1:0]    settle_cnt;
	logic [CNT_W-1:0]    eff_delay;
	logic [N_INPUTS-1:0] last_comb;
	logic [N_INPUTS-1:0] stable_comb;

	// Longer of built-in and configured delay
	assign eff_delay = (input_delay_cfg > CNT_W'(SETTLE_CNT)) ? input_delay_cfg : CNT_W'(SETTLE_CNT);

	// Restart the count on every input change
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			settle_cnt <= '0;
			last_comb  <= '0;
		end
		else
		begin
			last_comb <= a_sync;
			if (a_sync != last_comb)
				settle_cnt <= '0;
			else if (settle_cnt < eff_delay)
				settle_cnt <= settle_cnt + 1'b1;
		end
	end

	// Combination handed on only once settled
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			stable_comb <= '0;
		else if (settle_cnt >= eff_delay)
			stable_comb <= last_comb;
	end

	////////////////////////////////////////////////////////////////////////////
	// Scan and millisecond enables

	logic [CNT_W-1:0] scan_cnt;
	logic [CNT_W-1:0] ms_cnt;
	logic             scan_tick;
	logic             ms_tick;

	assign scan_tick = (scan_cnt == CNT_W'(SCAN_CNT - 1));
	assign ms_tick   = (ms_cnt == CNT_W'(MS_CNT - 1));

	// Free-running dividers
	always_ff @(posedge ref_clk)
	begin
		if (srst || scan_tick)
			scan_cnt <= '0;
		else
			scan_cnt <= scan_cnt + 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst || ms_tick)
			ms_cnt <= '0;
		else
			ms_cnt <= ms_cnt + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Speed evaluation

	logic [CNT_W-1:0]          mag_a;
	logic [CNT_W-1:0]          mag_b;
	logic [CNT_W-1:0]          mag_diff;
	logic signed [SPEED_W:0]   diff;
	logic signed [SPEED_W-1:0] speed_used;
	logic                      mismatch;
	logic [CNT_W-1:0]          mism_ms;
	logic                      any_limit;

	// Magnitude of a signed speed
	function automatic logic [CNT_W-1:0] mag(input logic signed [SPEED_W-1:0] v);
		mag = v[SPEED_W-1] ? CNT_W'(-$signed({v[SPEED_W-1], v})) : CNT_W'(v);
	endfunction

	assign mag_a      = mag(enc_speed_a);
	assign mag_b      = mag(enc_speed_b);
	// One bit wider so opposite speeds cannot wrap
	assign diff       = {enc_speed_a[SPEED_W-1], enc_speed_a} - {enc_speed_b[SPEED_W-1], enc_speed_b};
	assign mag_diff   = diff[SPEED_W] ? CNT_W'(-diff) : CNT_W'(diff);
	assign speed_used = (mag_a >= mag_b) ? enc_speed_a : enc_speed_b;
	assign mismatch   = (mag_diff * PCT_FULL) > (CNT_W'(speed_tol_pct) * ((mag_a >= mag_b) ? mag_a : mag_b));

	// Mismatch in limit mode ignored until the hold time runs out
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			mism_ms     <= '0;
			speed_fault <= 1'b0;
		end
		else if (!(mismatch && any_limit))
		begin
			mism_ms     <= '0;
			speed_fault <= 1'b0;
		end
		else if (mism_ms >= CNT_W'(MISMATCH_CNT))
			speed_fault <= 1'b1;
		else if (ms_tick)
			mism_ms <= mism_ms + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Monitoring case tables

	logic [N_TABLES-1:0] t_valid;
	logic [N_TABLES-1:0] t_seq;
	logic [N_TABLES-1:0] t_cfg;
	logic [N_TABLES-1:0] t_sleep;
	logic [N_TABLES-1:0] t_limv;
	logic [N_TABLES-1:0] t_limm;
	logic [N_TABLES-1:0][CASE_W-1:0] t_case;

	for (genvar t = 0; t < N_TABLES; t++)
	begin : g_tbl
		case_sel_if tif ();
		assign tif.eval            = scan_tick;
		assign tif.comb            = stable_comb;
		assign tif.use_speed       = use_speed[t];
		assign tif.speed           = speed_used;
		assign tif.inputs_used     = inputs_used[t];
		assign tif.case_comb       = case_comb[t];
		assign tif.case_use_inputs = case_use_inputs[t];
		assign tif.spd_mode        = spd_mode[t];
		assign tif.spd_min         = spd_min[t];
		assign tif.spd_max         = spd_max[t];
		assign tif.succ_cnt        = succ_cnt[t];
		assign tif.succ            = succ[t];
		assign tif.sleep_flag      = sleep_flag[t];
		assign t_case[t]           = tif.active;
		assign t_valid[t]          = tif.active_valid;
		assign t_seq[t]            = tif.seq_fault;
		assign t_cfg[t]            = tif.cfg_fault;
		assign t_sleep[t]          = tif.sleep;
		assign t_limv[t]           = tif.limit_viol;
		assign t_limm[t]           = tif.limit_mode;

		case_table_sel u_sel (
			.ref_clk (ref_clk),
			.srst    (srst),
			.sel     (tif.selector)
		);
	end

	assign any_limit = |t_limm;

	////////////////////////////////////////////////////////////////////////////
	// Supervisor state

	sup_state_t state;

	// Wait for all tables, then any loss is an error
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			state <= ST_WAIT;
		else if (scan_tick)
		begin
			case (state)
				ST_WAIT:  if (&t_valid) state <= ST_RUN;
				ST_RUN:   if (!(&t_valid)) state <= ST_ERROR;
				ST_ERROR: state <= ST_ERROR;
				default:  state <= ST_WAIT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Cut-off paths

	logic             all_ok;
	logic             safe_ok;
	logic [N_PATHS-1:0] safe_on;
	logic [N_PATHS-1:0] nonsafe_on;

	// Global gates for all outputs and for safety outputs
	assign all_ok  = (state == ST_RUN) && (&t_valid) && !(|t_cfg);
	assign safe_ok = all_ok && !(|t_seq) && !antivalent_fault && !speed_fault && !(|t_limv);

	// Each path reads the cell of its single owning table
	for (genvar p = 0; p < N_PATHS; p++)
	begin : g_path
		cut_beh_t beh;
		assign beh = cut_beh_t'(cell_beh[path_table[p]][t_case[path_table[p]]][p]);
		always_comb
		begin
			case (beh)
				BEH_FIELD:
				begin
					safe_on[p]    = field_clear[p];
					nonsafe_on[p] = field_clear[p];
				end
				BEH_ON_NONSAFE:
				begin
					safe_on[p]    = 1'b0;
					nonsafe_on[p] = 1'b1;
				end
				BEH_ON_SAFE:
				begin
					safe_on[p]    = 1'b1;
					nonsafe_on[p] = 1'b1;
				end
				default:
				begin
					safe_on[p]    = 1'b0;
					nonsafe_on[p] = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs applied at the scan boundary

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			safety_output_pair <= '0;
			path_on            <= '0;
		end
		else if (scan_tick)
		begin
			for (int p = 0; p < N_PATHS; p++)
			begin
				safety_output_pair[p] <= {2{safe_ok && safe_on[p] && path_pair_en[p]}};
				path_on[p]            <= all_ok && nonsafe_on[p];
			end
		end
	end

	// Universal outputs follow their assigned path
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			universal_out <= '0;
		else if (scan_tick)
			for (int u = 0; u < N_UNIV; u++)
				universal_out[u] <= all_ok && univ_en[u] && nonsafe_on[univ_path[u]];
	end

	// Status flags
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			waiting_for_inputs <= 1'b1;
			error_out          <= 1'b0;
			sleep_req          <= 1'b0;
			seq_fault          <= 1'b0;
			cfg_fault          <= 1'b0;
			active_case        <= '0;
			active_valid       <= '0;
		end
		else
		begin
			waiting_for_inputs <= (state == ST_WAIT);
			error_out          <= (state == ST_ERROR) || antivalent_fault || (|t_seq) || (|t_cfg);
			sleep_req          <= (state == ST_RUN) && (|t_sleep);
			seq_fault          <= |t_seq;
			cfg_fault          <= |t_cfg;
			active_case        <= t_case;
			active_valid       <= t_valid;
		end
	end

endmodule

// ### case_sup_props.sv
// Checker of the supervisor's output and fault relations.
// Bound to case_supervisor by the bench; scan 16, settle 20 cycles.
`timescale 1ns/1ps
module case_sup_props
	import case_sup_pkg::*;
(
	// Clock and reset
	input wire logic                    ref_clk,
	input wire logic                    srst,
	// Watched outputs
	input wire logic [N_PATHS-1:0][1:0] safety_output_pair,
	input wire logic [N_UNIV-1:0]       universal_out,
	input wire logic [N_TABLES-1:0]     active_valid,
	input wire logic                    waiting_for_inputs,
	input wire logic                    error_out,
	input wire logic                    seq_fault,
	input wire logic                    antivalent_fault,
	input wire logic                    sleep_req
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////
	// Off while waiting, off after faults
	a_wait_off: assert property (waiting_for_inputs |-> safety_output_pair == '0 && universal_out == '0)
		else $error("outputs on while waiting");
	a_seq_off: assert property ($rose(seq_fault) |-> ##[1:40] safety_output_pair == '0)
		else $error("pairs on after order fault");
	a_seq_hold: assert property (seq_fault |=> seq_fault)
		else $error("order fault dropped");
	a_seq_err: assert property (seq_fault |-> ##[0:2] error_out)
		else $error("order fault without error");
	a_anti_off: assert property ($rose(antivalent_fault) |-> ##[1:40] safety_output_pair == '0)
		else $error("pairs on after channel fault");
	a_anti_err: assert property (antivalent_fault |-> ##[0:2] error_out)
		else $error("channel fault without error");
	a_lost_off: assert property ($fell(&active_valid) |-> ##[1:40] (universal_out == '0 && error_out))
		else $error("lost case left outputs on");
	a_pair_same: assert property ((safety_output_pair & 8'h55) == ((safety_output_pair >> 1) & 8'h55))
		else $error("pair channels differ");
	a_sleep_run: assert property (sleep_req |-> !waiting_for_inputs)
		else $error("sleep while waiting");
	// Main scenarios
	c_seq: cover property ($rose(seq_fault));
	c_sleep: cover property ($rose(sleep_req));
	c_lost: cover property ($fell(&active_valid));
endmodule

// ### ctl_model.sv
// Machine controller and encoders feeding the supervisor.
// Bench sets the combination after a clock edge and holds it.
`timescale 1ns/1ps
module ctl_model
	import case_sup_pkg::*;
(
	// Bench commands
	input wire logic [N_INPUTS-1:0] comb,
	input wire logic                bad,
	input wire logic signed [SPEED_W-1:0] spd_a,
	input wire logic signed [SPEED_W-1:0] spd_b,
	// Pins and encoders
	output logic [N_INPUTS-1:0]         ctl_a,
	output logic [N_INPUTS-1:0]         ctl_b,
	output logic signed [SPEED_W-1:0]   enc_speed_a,
	output logic signed [SPEED_W-1:0]   enc_speed_b
);
	////////////////////////////////////////
	// Second channel inverted unless a fault is asked for
	assign ctl_a = comb;
	assign ctl_b = bad ? comb : ~comb;
	// Encoders report the speeds that the bench sets
	assign enc_speed_a = spd_a;
	assign enc_speed_b = spd_b;
endmodule

// ### tb_top.sv
// Self-checking bench of the monitoring case supervisor.
// Short counts: settle 20, scan 16 cycles; waits of 120 cover seven and a half scans.
`timescale 1ns/1ps
module tb_top;
	import case_sup_pkg::*;
	typedef struct packed {logic [3:0] c; logic [2:0] k; logic [7:0] p; logic [3:0] u;} row_t;
	// Pins, case, pairs, universal outputs
	row_t rows [5] = '{'{4'h1, 3'h0, 8'hcc, 4'he}, '{4'h2, 3'h1, 8'hcf, 4'hb},
		'{4'h3, 3'h2, 8'h00, 4'h0}, '{4'h4, 3'h3, 8'hff, 4'hf}, '{4'h1, 3'h0, 8'hcc, 4'he}};
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic bad = 1'b0;
	logic [3:0] comb = 4'h0;
	int n_errors = 0;
	int n_checks = 0;
	logic [N_INPUTS-1:0] ctl_a, ctl_b;
	logic signed [SPEED_W-1:0] spa, spb;
	logic [N_TABLES-1:0][N_CASES-1:0][N_INPUTS-1:0] cc = '0;
	logic [N_TABLES-1:0][N_CASES-1:0][1:0] sm = '0;
	logic [N_TABLES-1:0][N_CASES-1:0][1:0] sc = '0;
	logic [N_TABLES-1:0][N_CASES-1:0][N_SUCC-1:0][CASE_W-1:0] su = '0;
	logic [N_TABLES-1:0][N_CASES-1:0][N_PATHS-1:0][1:0] cb = '0;
	logic [N_TABLES-1:0][N_CASES-1:0] sf = '0;
	logic [N_PATHS-1:0][1:0] pr;
	logic [N_UNIV-1:0] uo;
	logic [N_TABLES-1:0][CASE_W-1:0] ac;
	logic [N_TABLES-1:0] av;
	logic wo, er, sq, cf, af, sl;
	logic ae = 1'b1;
	logic [31:0] dly = '0;
	logic [6:0] tol = 7'h0a;
	logic [1:0] us = 2'h3;
	logic [7:0] iu = 8'h87;
	logic [3:0] fc = 4'hb;
	logic [N_TABLES-1:0][N_CASES-1:0][SPEED_W-1:0] smin = {16{16'h7fff}}, smax = '0;
	logic signed [SPEED_W-1:0] sa = 16'sh0005, sb = 16'sh0005;
	logic [N_PATHS-1:0] po;
	logic sfl;
	////////////////////////////////////////
	// Clock and partner
	always #2.5 ref_clk = ~ref_clk;
	ctl_model ctl (.comb(comb), .bad(bad), .spd_a(sa), .spd_b(sb), .ctl_a(ctl_a), .ctl_b(ctl_b),
		.enc_speed_a(spa), .enc_speed_b(spb));
	case_supervisor #(.SETTLE_CNT(20), .SCAN_CNT(16), .MS_CNT(10), .MISMATCH_CNT(5)) dut (
		.ref_clk(ref_clk), .srst(srst), .ctl_a(ctl_a), .ctl_b(ctl_b), .antivalent_en(ae),
		.input_delay_cfg(dly), .enc_speed_a(spa), .enc_speed_b(spb), .speed_tol_pct(tol),
		.use_speed(us), .inputs_used(iu), .case_comb(cc), .case_use_inputs(16'h0000), .spd_mode(sm),
		.spd_min(smin), .spd_max(smax), .succ_cnt(sc), .succ(su), .sleep_flag(sf), .cell_beh(cb),
		.path_table(4'h0), .path_pair_en(4'hf), .univ_path(8'he4), .univ_en(4'hf), .field_clear(fc),
		.safety_output_pair(pr), .universal_out(uo), .path_on(po), .active_case(ac), .active_valid(av),
		.waiting_for_inputs(wo), .error_out(er), .seq_fault(sq), .cfg_fault(cf),
		.antivalent_fault(af), .speed_fault(sfl), .sleep_req(sl));
	// Shared helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic rst();
		srst <= 1'b1;
		wt(20);
		srst <= 1'b0;
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Configuration, rows, then awkward cases
	initial
	begin
		for (int k = 0; k < 8; k++)
		begin
			cc[0][k] <= k < 4 ? 4'(k + 1) : 4'h0;
			sm[0][k] <= k < 4 ? 2'b00 : 2'b01;
			sm[1][k] <= k < 1 ? 2'b00 : 2'b01;
		end
		sc[0][0] <= 2'h1;
		su[0][0][0] <= 3'h1;
		sc[0][1] <= 2'h2;
		su[0][1][1] <= 3'h2;
		sc[0][3] <= 2'h1;
		cb[0][0] <= {BEH_ON_SAFE, BEH_ON_NONSAFE, BEH_FIELD, BEH_OFF};
		cb[0][1] <= {4{BEH_FIELD}};
		cb[0][3] <= {4{BEH_ON_SAFE}};
		sf[0][3] <= 1'b1;
		wt(20);
		srst <= 1'b0;
		repeat (60)
		begin
			wt(1);
			chk(er, 0);
		end
		chk(wo, 1);
		chk(pr, 0);
		foreach (rows[i])
		begin
			comb <= rows[i].c;
			wt(120);
			chk(ac[0], rows[i].k);
			chk(pr, rows[i].p);
			chk(uo, rows[i].u);
			chk(po, rows[i].u);
			chk(sl, rows[i].k == 3'h3);
		end
		chk(cf, 0);
		$display("test rows done");
		comb <= 4'h3;
		wt(120);
		chk(sq, 1);
		chk(pr, 0);
		chk(ac[0], 0);
		$display("test order done");
		comb <= 4'h4;
		rst();
		wt(120);
		chk(sq, 0);
		comb <= 4'h1;
		wt(10);
		comb <= 4'h4;
		wt(120);
		chk(ac[0], 3);
		chk(pr, 8'hff);
		dly <= 32'h0000_003c;
		comb <= 4'h1;
		wt(40);
		comb <= 4'h4;
		wt(120);
		chk(ac[0], 3);
		chk(sq, 0);
		dly <= '0;
		$display("test settle done");
		bad <= 1'b1;
		wt(120);
		chk(af, 1);
		chk(er, 1);
		chk(pr, 0);
		bad <= 1'b0;
		$display("test channels done");
		rst();
		wt(120);
		comb <= 4'h7;
		wt(120);
		chk(av[0], 0);
		chk(er, 1);
		chk(uo, 0);
		chk(wo, 0);
		$display("test lost case done");
		smin[0][4] <= '0;
		smax[0][4] <= 16'h000a;
		rst();
		wt(120);
		chk(ac[0], 4);
		chk(pr, 0);
		chk(er, 0);
		us <= 2'h2;
		wt(120);
		chk(av[0], 0);
		chk(cf, 1);
		$display("test speed range done");
		us <= 2'h3;
		sm[0][0] <= 2'h2;
		smin[0][0] <= '0;
		smax[0][0] <= 16'h0003;
		comb <= 4'h1;
		rst();
		wt(120);
		chk(pr, 0);
		chk(uo, 4'he);
		smax[0][0] <= 16'h000a;
		wt(120);
		chk(pr, 8'hcc);
		sb <= 16'sh0002;
		wt(30);
		chk(pr, 8'hcc);
		wt(90);
		chk(sfl, 1);
		chk(pr, 0);
		$display("test speed limit done");
		test_done();
	end
endmodule
bind case_supervisor case_sup_props u_props (.ref_clk(ref_clk), .srst(srst),
	.safety_output_pair(safety_output_pair), .universal_out(universal_out), .active_valid(active_valid),
	.waiting_for_inputs(waiting_for_inputs), .error_out(error_out), .seq_fault(seq_fault),
	.antivalent_fault(antivalent_fault), .sleep_req(sleep_req));
